// ==== hdl/bcie_core.v ====
/*
  Instruction execution core of an 8-bit microcomputer: fetch sequencing,
  fetch-source select, strobe cadence, accumulator instruction execution.
  Assumes program bytes arrive on code_data_in one oscillator period after
  code_addr_out, and direct/indirect/register operands on opnd_data_in.
*/
// How it works
// - Add operand to accumulator, one cycle; 1 or 2 bytes by form
// - Add with carry sums accumulator, operand and carry in one cycle
// - Subtract operand and borrow from accumulator in one cycle
// - AND into accumulator completes in one cycle
// - AND immediate into direct byte is 3 bytes, 2 cycles
// - OR has AND's forms; immediate-to-direct 3 bytes, 2 cycles
// - XOR has AND's forms; immediate-to-direct 3 bytes, 2 cycles
// - Rotate left or right, with or without carry, 1 byte 1 cycle
// - Swap nibbles, clear, complement accumulator, 1 byte 1 cycle
// - Moves into accumulator take one cycle; 1 or 2 bytes by form
// - Program strobe pulses every six periods externally, skips data access
// - Address latch strobe every six periods, every slot skipped during data access
// - Select high: internal fetch below 4096, external at or above
// - Select low: every fetch is external
// - High reset input resets the core; outside holds it long enough
`timescale 1ns/1ps
`include "bcie_regs.vh"

module bcie_core (
  input wire clock_in,
  input wire rst_in,
  input wire ext_access_select_n_in,
  input wire ext_data_access_in,
  input wire [7:0] code_data_in,
  input wire [7:0] opnd_data_in,
  output reg [15:0] code_addr_out,
  output reg prog_store_strobe_n_out,
  output reg addr_latch_strobe_out,
  output reg fetch_external_out,
  output reg [7:0] opnd_addr_out,
  output reg [7:0] wr_data_out,
  output reg wr_en_out,
  output reg [7:0] acc_out,
  output reg carry_out,
  output reg [15:0] data_pointer_reg_out,
  output reg instr_done_out
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam ST_OP = 2'd0;
  localparam ST_B2 = 2'd1;
  localparam ST_B3 = 2'd2;
  localparam ST_EXEC = 2'd3;

  reg [3:0] phase_ff;
  reg [1:0] state_ff;
  reg [7:0] opcode_ff;
  reg [7:0] byte2_ff;
  reg [7:0] byte3_ff;
  reg [2:0] cyc_left_ff;
  reg [7:0] b_reg_ff;
  reg [15:0] pc_ff;
  reg [7:0] nxt_acc;
  reg nxt_carry;
  reg [3:0] alu_op;
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  reg [1:0] len;
  reg [2:0] cycles;
  reg to_direct;
  wire [7:0] alu_res;
  wire alu_c;
  wire [3:0] grp;
  wire [3:0] low;
  wire mcyc_end;
  wire half_slot;
  wire ext_fetch;

  assign grp = opcode_ff[7:4];
  assign low = opcode_ff[3:0];
  assign mcyc_end = (phase_ff == `BCIE_OSC_PER_MCYC - 4'd1);
  assign half_slot = (phase_ff == 4'd0) || (phase_ff == `BCIE_OSC_PER_STROBE);

  // ----------------------------------------
  // Fetch source select
  // ----------------------------------------
  assign ext_fetch = !ext_access_select_n_in ? 1'b1 :
    (pc_ff >= `BCIE_INT_ROM_LIMIT);

  // ----------------------------------------
  // Strobes: two slots per machine cycle
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      phase_ff <= 4'd0;
      addr_latch_strobe_out <= 1'b0;
      prog_store_strobe_n_out <= 1'b1;
      fetch_external_out <= 1'b0;
    end else begin
      phase_ff <= mcyc_end ? 4'd0 : phase_ff + 4'd1;
      addr_latch_strobe_out <= half_slot && !ext_data_access_in;
      prog_store_strobe_n_out <= !(ext_fetch && !ext_data_access_in &&
        (phase_ff == 4'd2 || phase_ff == 4'd8));
      fetch_external_out <= ext_fetch;
    end
  end

  // ----------------------------------------
  // Decode length and cycles of current opcode
  // ----------------------------------------
  always @* begin
    len = 2'd1;
    cycles = `BCIE_CYC_ONE;
    to_direct = 1'b0;
    alu_op = 4'hd;
    alu_a = acc_out;
    alu_b = opnd_data_in;
    if (low == 4'h4) begin
      len = 2'd2;
      alu_b = byte2_ff;
    end else if (low == 4'h5) begin
      len = 2'd2;
    end
    case (grp)
      `BCIE_GRP_ADD: alu_op = 4'h0;
      `BCIE_GRP_OP_ADD_CARRY: alu_op = 4'h1;
      `BCIE_GRP_OP_SUB_BORROW: alu_op = 4'h2;
      `BCIE_GRP_AND: alu_op = 4'h3;
      `BCIE_GRP_OR: alu_op = 4'h4;
      `BCIE_GRP_XOR: alu_op = 4'h5;
      `BCIE_GRP_MOVA: alu_op = 4'hd;
      default: alu_op = 4'hd;
    endcase
    if ((grp == `BCIE_GRP_AND || grp == `BCIE_GRP_OR || grp == `BCIE_GRP_XOR) &&
        (low == 4'h2 || low == 4'h3)) begin
      to_direct = 1'b1;
      alu_a = opnd_data_in;
      alu_b = (low == 4'h3) ? byte3_ff : acc_out;
      len = (low == 4'h3) ? 2'd3 : 2'd2;
      cycles = (low == 4'h3) ? `BCIE_CYC_TWO : `BCIE_CYC_ONE;
    end
    case (opcode_ff)
      `BCIE_OP_MOV_IMM: begin
        len = 2'd2;
        alu_op = 4'hd;
      end
      `BCIE_OP_RL: alu_op = 4'h6;
      `BCIE_OP_RLC: alu_op = 4'h7;
      `BCIE_OP_RR: alu_op = 4'h8;
      `BCIE_OP_RRC: alu_op = 4'h9;
      `BCIE_OP_SWAP: alu_op = 4'ha;
      `BCIE_OP_CLR: alu_op = 4'hb;
      `BCIE_OP_CPL: alu_op = 4'hc;
      `BCIE_OP_MUL, `BCIE_OP_DIV: cycles = `BCIE_CYC_FOUR;
      `BCIE_OP_INC_DATA_POINTER_REG: cycles = `BCIE_CYC_TWO;
      default: cycles = cycles;
    endcase
    if (opcode_ff == `BCIE_OP_RL || opcode_ff == `BCIE_OP_RLC ||
        opcode_ff == `BCIE_OP_RR || opcode_ff == `BCIE_OP_RRC ||
        opcode_ff == `BCIE_OP_SWAP || opcode_ff == `BCIE_OP_CLR ||
        opcode_ff == `BCIE_OP_CPL || opcode_ff == `BCIE_OP_MUL ||
        opcode_ff == `BCIE_OP_DIV || opcode_ff == `BCIE_OP_INC_DATA_POINTER_REG) begin
      len = 2'd1;
    end
  end

  bcie_alu u_alu (
    .op_in(alu_op),
    .acc_in(alu_a),
    .opnd_in(alu_b),
    .carry_in(carry_out),
    .res_out(alu_res),
    .carry_out(alu_c)
  );

  // ----------------------------------------
  // Writeback select
  // ----------------------------------------
  wire known_acc_op;
  assign known_acc_op = (grp == `BCIE_GRP_ADD || grp == `BCIE_GRP_OP_ADD_CARRY ||
    grp == `BCIE_GRP_OP_SUB_BORROW || grp == `BCIE_GRP_AND || grp == `BCIE_GRP_OR ||
    grp == `BCIE_GRP_XOR) && (low >= 4'h4) ||
    (grp == `BCIE_GRP_MOVA && low >= 4'h5) || opcode_ff == `BCIE_OP_MOV_IMM ||
    opcode_ff == `BCIE_OP_RL || opcode_ff == `BCIE_OP_RLC ||
    opcode_ff == `BCIE_OP_RR || opcode_ff == `BCIE_OP_RRC ||
    opcode_ff == `BCIE_OP_SWAP || opcode_ff == `BCIE_OP_CLR ||
    opcode_ff == `BCIE_OP_CPL;

  always @* begin
    nxt_acc = acc_out;
    nxt_carry = carry_out;
    if (known_acc_op && !to_direct) begin
      nxt_acc = alu_res;
      nxt_carry = alu_c;
    end
  end

  // ----------------------------------------
  // Sequencer: one byte per strobe slot
  // ----------------------------------------
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= ST_OP;
      pc_ff <= `BCIE_RESET_PC;
      code_addr_out <= `BCIE_RESET_PC;
      opcode_ff <= `BCIE_OP_NOP;
      byte2_ff <= 8'h00;
      byte3_ff <= 8'h00;
      cyc_left_ff <= 3'd0;
      acc_out <= `BCIE_RESET_ACC;
      carry_out <= 1'b0;
      b_reg_ff <= 8'h00;
      data_pointer_reg_out <= 16'h0000;
      opnd_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
      wr_en_out <= 1'b0;
      instr_done_out <= 1'b0;
    end else begin
      wr_en_out <= 1'b0;
      instr_done_out <= 1'b0;
      case (state_ff)
        ST_OP: if (half_slot) begin
          opcode_ff <= code_data_in;
          opnd_addr_out <= {5'h00, code_data_in[2:0]};
          pc_ff <= pc_ff + 16'h0001;
          code_addr_out <= pc_ff + 16'h0001;
          state_ff <= ST_B2;
        end
        ST_B2: if (half_slot) begin
          if (len != 2'd1) begin
            byte2_ff <= code_data_in;
            opnd_addr_out <= code_data_in;
            pc_ff <= pc_ff + 16'h0001;
            code_addr_out <= pc_ff + 16'h0001;
          end
          state_ff <= (len == 2'd3) ? ST_B3 : ST_EXEC;
          // Third byte slot already opens the second machine cycle
          cyc_left_ff <= (len == 2'd3) ? cycles - 3'd1 : cycles;
        end
        ST_B3: if (half_slot) begin
          byte3_ff <= code_data_in;
          pc_ff <= pc_ff + 16'h0001;
          code_addr_out <= pc_ff + 16'h0001;
          state_ff <= ST_EXEC;
        end
        ST_EXEC: if (mcyc_end) begin
          if (cyc_left_ff > 3'd1) begin
            cyc_left_ff <= cyc_left_ff - 3'd1;
          end else begin
            acc_out <= nxt_acc;
            carry_out <= nxt_carry;
            if (to_direct) begin
              wr_data_out <= alu_res;
              wr_en_out <= 1'b1;
            end
            if (opcode_ff == `BCIE_OP_INC_DATA_POINTER_REG) begin
              data_pointer_reg_out <= data_pointer_reg_out + 16'h0001;
            end
            if (opcode_ff == `BCIE_OP_MUL) begin
              {b_reg_ff, acc_out} <= acc_out * b_reg_ff;
              carry_out <= 1'b0;
            end
            instr_done_out <= 1'b1;
            state_ff <= ST_OP;
          end
        end
        default: state_ff <= ST_OP;
      endcase
    end
  end

endmodule

// ==== pkg/bcie_regs.vh ====
/*
  Constants of the byte core execution block: timing slots, fetch limit,
  opcodes of the executed instruction groups and cycle counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BCIE_REGS_VH
`define BCIE_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCIE_OSC_PER_MCYC 4'd12
`define BCIE_OSC_PER_STROBE 4'd6
`define BCIE_INT_ROM_LIMIT 16'h1000
`define BCIE_RESET_PC 16'h0000
`define BCIE_RESET_ACC 8'h00
`define BCIE_RESET_SP 8'h07

// ----------------------------------------
// Opcode groups (upper nibble)
// ----------------------------------------
`define BCIE_GRP_ADD 4'h2
`define BCIE_GRP_OP_ADD_CARRY 4'h3
`define BCIE_GRP_OR 4'h4
`define BCIE_GRP_AND 4'h5
`define BCIE_GRP_XOR 4'h6
`define BCIE_GRP_OP_SUB_BORROW 4'h9
`define BCIE_GRP_MOVA 4'he

// ----------------------------------------
// Single opcodes
// ----------------------------------------
`define BCIE_OP_NOP 8'h00
`define BCIE_OP_RR 8'h03
`define BCIE_OP_RRC 8'h13
`define BCIE_OP_RL 8'h23
`define BCIE_OP_RLC 8'h33
`define BCIE_OP_MOV_IMM 8'h74
`define BCIE_OP_MUL 8'ha4
`define BCIE_OP_DIV 8'h84
`define BCIE_OP_INC_DATA_POINTER_REG 8'ha3
`define BCIE_OP_SWAP 8'hc4
`define BCIE_OP_CLR 8'he4
`define BCIE_OP_CPL 8'hf4

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define BCIE_CYC_ONE 3'd1
`define BCIE_CYC_TWO 3'd2
`define BCIE_CYC_FOUR 3'd4

`endif

// ==== hdl/bcie_alu.v ====
/*
  Accumulator ALU of the byte core: add, add with carry, subtract with
  borrow, logic, rotate, swap, clear, complement, move.
  Assumes the caller presents a decoded operation and holds it stable.
*/
`timescale 1ns/1ps

module bcie_alu (
  input wire [3:0] op_in,
  input wire [7:0] acc_in,
  input wire [7:0] opnd_in,
  input wire carry_in,
  output reg [7:0] res_out,
  output reg carry_out
);

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  localparam ALU_ADD = 4'h0;
  localparam ALU_OP_ADD_CARRY = 4'h1;
  localparam ALU_OP_SUB_BORROW = 4'h2;
  localparam ALU_AND = 4'h3;
  localparam ALU_OR = 4'h4;
  localparam ALU_XOR = 4'h5;
  localparam ALU_RL = 4'h6;
  localparam ALU_RLC = 4'h7;
  localparam ALU_RR = 4'h8;
  localparam ALU_RRC = 4'h9;
  localparam ALU_SWAP = 4'ha;
  localparam ALU_CLR = 4'hb;
  localparam ALU_CPL = 4'hc;
  localparam ALU_MOVE = 4'hd;

  reg [8:0] sum;

  always @* begin
    sum = 9'h000;
    res_out = acc_in;
    carry_out = carry_in;
    case (op_in)
      ALU_ADD: begin
        sum = {1'b0, acc_in} + {1'b0, opnd_in};
        res_out = sum[7:0];
        carry_out = sum[8];
      end
      ALU_OP_ADD_CARRY: begin
        sum = {1'b0, acc_in} + {1'b0, opnd_in} + {8'h00, carry_in};
        res_out = sum[7:0];
        carry_out = sum[8];
      end
      ALU_OP_SUB_BORROW: begin
        sum = {1'b0, acc_in} - {1'b0, opnd_in} - {8'h00, carry_in};
        res_out = sum[7:0];
        carry_out = sum[8];
      end
      ALU_AND: res_out = acc_in & opnd_in;
      ALU_OR: res_out = acc_in | opnd_in;
      ALU_XOR: res_out = acc_in ^ opnd_in;
      ALU_RL: res_out = {acc_in[6:0], acc_in[7]};
      ALU_RLC: begin
        res_out = {acc_in[6:0], carry_in};
        carry_out = acc_in[7];
      end
      ALU_RR: res_out = {acc_in[0], acc_in[7:1]};
      ALU_RRC: begin
        res_out = {carry_in, acc_in[7:1]};
        carry_out = acc_in[0];
      end
      ALU_SWAP: res_out = {acc_in[3:0], acc_in[7:4]};
      ALU_CLR: res_out = 8'h00;
      ALU_CPL: res_out = ~acc_in;
      ALU_MOVE: res_out = opnd_in;
      default: res_out = acc_in;
    endcase
  end

endmodule

// ==== verification/bcie_core_asserts.sv ====
/* Checker of the byte core ports: strobe cadence, fetch source, reset, pulses.
   Assumes a bind to bcie_core and one clock domain. */
`timescale 1ns/1ps
module bcie_core_asserts (
  input wire clock_in,
  input wire rst_in,
  input wire ext_access_select_n_in,
  input wire ext_data_access_in,
  input wire [15:0] code_addr_out,
  input wire prog_store_strobe_n_out,
  input wire addr_latch_strobe_out,
  input wire fetch_external_out,
  input wire wr_en_out,
  input wire [7:0] acc_out,
  input wire carry_out,
  input wire instr_done_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_no_data;
    (!ext_data_access_in)[*6];
  endsequence
  sequence s_ext_run;
    (fetch_external_out && !ext_data_access_in)[*6];
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    rst_in |=> code_addr_out == 16'h0000 && acc_out == 8'h00 && !carry_out
    && prog_store_strobe_n_out && !addr_latch_strobe_out && !instr_done_out && !wr_en_out)
    else $error("reset state wrong");
  a_ale_period: assert property (
    (addr_latch_strobe_out && !ext_data_access_in) ##1 s_no_data |-> addr_latch_strobe_out)
    else $error("address strobe period wrong");
  a_ale_width: assert property (
    addr_latch_strobe_out |=> (!addr_latch_strobe_out)[*5]) else $error("address strobe width");
  a_prog_store_strobe_n_period: assert property (
    (!prog_store_strobe_n_out && !ext_data_access_in) ##1 s_ext_run
    |-> !prog_store_strobe_n_out) else $error("program strobe period wrong");
  a_prog_store_strobe_n_internal: assert property (
    (!fetch_external_out)[*3] |-> prog_store_strobe_n_out) else $error("program strobe low");
  a_data_skip: assert property (
    ext_data_access_in[*3] |-> !addr_latch_strobe_out && prog_store_strobe_n_out)
    else $error("strobe during data access");
  a_select_low: assert property (
    (!ext_access_select_n_in)[*2] |-> fetch_external_out) else $error("fetch not external");
  a_select_high: assert property (
    (ext_access_select_n_in && code_addr_out < 16'h1000)[*2] |-> !fetch_external_out)
    else $error("fetch not internal");
  a_done_spacing: assert property (
    instr_done_out |=> (!instr_done_out)[*8]) else $error("done pulses too close");
  a_wr_pulse: assert property (
    wr_en_out |=> !wr_en_out) else $error("write pulse too long");
endmodule
bind bcie_core bcie_core_asserts u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .ext_access_select_n_in(ext_access_select_n_in), .ext_data_access_in(ext_data_access_in),
  .code_addr_out(code_addr_out), .prog_store_strobe_n_out(prog_store_strobe_n_out),
  .addr_latch_strobe_out(addr_latch_strobe_out), .fetch_external_out(fetch_external_out),
  .wr_en_out(wr_en_out), .acc_out(acc_out), .carry_out(carry_out),
  .instr_done_out(instr_done_out));

// ==== verification/bcie_prog_mem.sv ====
/* Program memory model: one byte a clock from the fetch address.
   Assumes the bench loads mem before reset is released. */
`timescale 1ns/1ps
module bcie_prog_mem (
  input wire clock_in,
  input wire [15:0] code_addr_in,
  output reg [7:0] code_data_out
);
  reg [7:0] mem [0:255];
  initial code_data_out = 8'h00;
  always @(posedge clock_in) begin
    code_data_out <= mem[code_addr_in[7:0]];
  end
endmodule

// ==== verification/bcie_core_tb.sv ====
/* Bench of the byte core: corner and random programs, timing, strobes.
   Assumes the program memory model and the bound checker. */
`timescale 1ns/1ps
module bcie_core_tb;
  localparam [71:0] ST = 72'h03_13_23_33_c4_e4_f4_74_00;
  localparam [27:0] GT = 28'h234569e;
  reg clock_in = 1'b0;
  reg rst_in = 1'b1;
  reg sel_n = 1'b1;
  reg eda = 1'b0;
  reg [7:0] opnd = 8'h00;
  wire [7:0] cdat, wd, acc, oa;
  wire [15:0] ca, dp;
  wire psn, ale, fx, wen, cy, done;
  reg [7:0] opq [0:63];
  reg [7:0] b2q [0:63];
  reg [7:0] b3q [0:63];
  reg [7:0] vq [0:63];
  integer failures = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer n, k, r;
  reg [17:0] pr;
  reg [15:0] base;
  reg [7:0] ea;
  reg [3:0] g, lo;
  reg ec;
  always #2.5 clock_in = ~clock_in;
  bcie_core uut (.clock_in(clock_in), .rst_in(rst_in), .ext_access_select_n_in(sel_n),
    .ext_data_access_in(eda), .code_data_in(cdat), .opnd_data_in(opnd),
    .code_addr_out(ca), .prog_store_strobe_n_out(psn), .addr_latch_strobe_out(ale),
    .fetch_external_out(fx), .opnd_addr_out(oa), .wr_data_out(wd), .wr_en_out(wen),
    .acc_out(acc), .carry_out(cy), .data_pointer_reg_out(dp), .instr_done_out(done));
  bcie_prog_mem pm (.clock_in(clock_in), .code_addr_in(ca), .code_data_out(cdat));
  // ----------------------------------------
  // Expectation
  // ----------------------------------------
  function [15:0] blen(input [7:0] o);
    begin
      blen = 16'd1;
      if (o[3:0] == 4'h2 || o[3:0] == 4'h5 || (o[3:0] == 4'h4 && (!o[7] || o == 8'h94)))
        blen = 16'd2;
      if (o[3:0] == 4'h3 && o[6])
        blen = 16'd3;
    end
  endfunction
  function [15:0] ncyc(input [7:0] o);
    begin
      ncyc = 16'd12;
      if (o == 8'h43 || o == 8'h53 || o == 8'h63 || o == 8'ha3)
        ncyc = 16'd24;
      if (o == 8'ha4 || o == 8'h84)
        ncyc = 16'd48;
    end
  endfunction
  function [7:0] lg(input [3:0] f, input [7:0] p, input [7:0] q);
    lg = (f == 4'h4) ? (p | q) : (f == 4'h5) ? (p & q) : (p ^ q);
  endfunction
  function [17:0] predict(input [7:0] o, input [7:0] b2, input [7:0] b3, input [7:0] v,
    input [7:0] a, input c);
    reg [8:0] s, w;
    reg [7:0] x;
    begin
      x = (o[3:0] == 4'h4) ? b2 : v;
      s = {c, a};
      w = 9'h000;
      case (o)
        8'h03: s = {c, a[0], a[7:1]};
        8'h13: s = {a[0], c, a[7:1]};
        8'h23: s = {c, a[6:0], a[7]};
        8'h33: s = {a, c};
        8'hc4: s = {c, a[3:0], a[7:4]};
        8'he4: s = {c, 8'h00};
        8'hf4: s = {c, ~a};
        8'h74: s = {c, b2};
        default: case (o[7:4])
          4'h2: s = a + x;
          4'h3: s = a + x + c;
          4'h9: s = {1'b0, a} - x - c;
          4'he: s = {c, x};
          4'h4, 4'h5, 4'h6: begin
            if (o[3:1] == 3'h1)
              w = {1'b1, lg(o[7:4], v, o[0] ? b3 : a)};
            else
              s = {c, lg(o[7:4], a, x)};
          end
          default: s = {c, a};
        endcase
      endcase
      predict = {w, s};
    end
  endfunction
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [79:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task emit(input [7:0] o, input [7:0] b2, input [7:0] b3);
    begin
      opq[n] = o;
      b2q[n] = b2;
      b3q[n] = b3;
      vq[n] = 8'($urandom);
      n = n + 1;
    end
  endtask
  task run_prog(input chk);
    integer i, pc;
    reg [15:0] t;
    reg [7:0] sd;
    reg sw;
    begin
      for (i = 0; i < 256; i = i + 1)
        pm.mem[i] = 8'h00;
      pc = 0;
      for (i = 0; i < n; i = i + 1) begin
        pm.mem[pc] = opq[i];
        pm.mem[pc + 1] = b2q[i];
        pm.mem[pc + 2] = b3q[i];
        pc = pc + blen(opq[i]);
      end
      ea = 8'h00;
      ec = 1'b0;
      rst_in = 1'b1;
      opnd = vq[0];
      repeat (2) @(negedge clock_in);
      rst_in = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        t = 16'd0;
        sw = 1'b0;
        sd = 8'h00;
        do begin
          @(negedge clock_in);
          t = t + 16'd1;
          sw = sw | (wen === 1'b1);
          if (wen === 1'b1)
            sd = wd;
        end while (done !== 1'b1 && t < 16'd100);
        if (i + 1 < n)
          opnd = vq[i + 1];
        if (i == 0)
          base = dp;
        pr = predict(opq[i], b2q[i], b3q[i], vq[i], ea, ec);
        if (i > 0)
          check("gap", t, ncyc(opq[i]));
        if (chk) begin
          check("acc", acc, pr[7:0]);
          check("carry", cy, pr[8]);
          check("wr_en", sw, pr[17]);
          if (pr[17])
            check("wr_data", sd, pr[16:9]);
          if (opq[i][3:0] == 4'h5 || (opq[i][7:6] == 2'b01 && opq[i][3:1] == 3'h1))
            check("opnd_addr", oa, b2q[i]);
        end
        ea = pr[7:0];
        ec = pr[8];
      end
    end
  endtask
  task strobes(input [15:0] xa, input [15:0] xp);
    integer i;
    reg [15:0] na, np;
    begin
      na = 16'd0;
      np = 16'd0;
      for (i = 0; i < 24; i = i + 1) begin
        @(negedge clock_in);
        na = na + (ale === 1'b1);
        np = np + (psn === 1'b0);
      end
      check("ale_cnt", na, xa);
      check("prog_store_strobe_n_cnt", np, xp);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      test_done;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    r = $urandom(32'h337c);
    n = 0;
    emit(8'h74, 8'hff, 8'h00);
    emit(8'h24, 8'h01, 8'h00);
    emit(8'h34, 8'hff, 8'h00);
    emit(8'h94, 8'h00, 8'h00);
    for (k = 0; k < 40; k = k + 1) begin
      r = $urandom % 16;
      g = GT[4 * (r % 7) +: 4];
      lo = 4'(4 + $urandom % 12);
      if (g[3:2] == 2'b01)
        lo = 4'(2 + $urandom % 14);
      if (r < 9)
        emit(ST[8 * r +: 8], 8'($urandom), 8'($urandom));
      else
        emit({g, lo}, 8'($urandom), 8'($urandom));
    end
    emit(8'h00, 8'h00, 8'h00);
    run_prog(1'b1);
    check("fetch_ext", fx, 1'b0);
    strobes(16'd4, 16'd0);
    $display("test internal fetch done");
    sel_n = 1'b0;
    run_prog(1'b1);
    check("fetch_ext", fx, 1'b1);
    strobes(16'd4, 16'd4);
    eda = 1'b1;
    repeat (3) @(negedge clock_in);
    strobes(16'd0, 16'd0);
    eda = 1'b0;
    $display("test external fetch done");
    n = 0;
    emit(8'h00, 8'h00, 8'h00);
    emit(8'ha3, 8'h00, 8'h00);
    emit(8'ha4, 8'h00, 8'h00);
    emit(8'h84, 8'h00, 8'h00);
    emit(8'ha3, 8'h00, 8'h00);
    emit(8'h00, 8'h00, 8'h00);
    run_prog(1'b0);
    check("data_pointer_reg", dp - base, 16'd2);
    $display("test long instructions done");
    test_done;
  end
endmodule
